// [rtl/rdsrp_pkg.sv]
// How it works
// - factory 0, mode 0: master, clock driven
// - factory 0, mode 1: slave, clock input
// - factory 1, mode 0: standby, pins undefined
// - reset pin clears detection; slave empties buffer
// - master flag shows current data reliability
// - flag pin only pulls low or releases
// - master holds clock, data high until detection
// - slave data valid within data valid delay
// - ready falls when empty, rises on store
// - nothing stored before first detection after reset
// - storing continues after first detection
// - buffer continues from item after last delivered; a switch from master in MST_IDLE or MST_HIGH skips the head bit, in MST_HIGH the popped bit too
package rdsrp_pkg;
   // ******************************************
   // timing
   // ******************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int DATA_VALID_DELAY_NS = 750;
   localparam int READY_CHECK_DELAY_NS = 750;
   // longest times round down
   localparam int DATA_VALID_CYCLES = DATA_VALID_DELAY_NS / CLK_PERIOD_NS;
   localparam int READY_CHECK_CYCLES = READY_CHECK_DELAY_NS / CLK_PERIOD_NS;
   localparam int BUF_DEPTH = 128;
   // ******************************************
   // register map
   // ******************************************
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0010;
   localparam int CTRL_HALF_LSB = 0;
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_STARTED_BIT = 1;
   localparam int STAT_RELIABLE_BIT = 2;
   localparam int STAT_OVERRUN_BIT = 3;
   localparam int STAT_SLAVE_BIT = 4;
   localparam int STAT_STANDBY_BIT = 5;
   localparam int STAT_FILL_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ******************************************
   // types
   // ******************************************
   typedef enum logic [1:0] {MD_MASTER, MD_SLAVE, MD_STANDBY, MD_TEST} rdsrp_mode_t;
   typedef enum logic [1:0] {MST_IDLE, MST_HIGH, MST_LOW} rdsrp_mst_t;
   // pin pair to operating mode
   function automatic rdsrp_mode_t mode_of(input logic factory, input logic mode);
      case ({factory, mode})
         2'b00: mode_of = MD_MASTER;
         2'b01: mode_of = MD_SLAVE;
         2'b10: mode_of = MD_STANDBY;
         default: mode_of = MD_TEST;
      endcase
   endfunction
endpackage

// [rtl/rdsrp_top.sv]
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module rdsrp_top #(
   parameter int DEPTH = rdsrp_pkg::BUF_DEPTH
) (
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic [3:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [3:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic FACTORY_PIN,
   input wire logic MODE_PIN,
   input wire logic CLEAR_PIN,
   input wire logic DEMOD_BIT,
   input wire logic DEMOD_VALID,
   input wire logic DEMOD_RELIABLE,
   input wire logic DETECT,
   input wire logic BIT_CLOCK_IN,
   output logic BIT_CLOCK_OUT,
   output logic BIT_CLOCK_OE,
   output logic SERIAL_DATA,
   output logic FLAG_OUT,
   output logic FLAG_OE,
   output logic STANDBY
);
   import rdsrp_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam int DV_MAX = DATA_VALID_CYCLES;
   localparam int RC_MAX = READY_CHECK_CYCLES;

   // ******************************************
   // pin synchronisers
   // ******************************************
   logic [1:0] fac_s, mod_s, clr_s;
   logic [2:0] bck_s;
   // first stage feeds only the second; bck_s[2] is the edge history
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         fac_s <= 2'h0;
         mod_s <= 2'h0;
         clr_s <= 2'h0;
         bck_s <= 3'h0;
      end else begin
         fac_s <= {fac_s[0], FACTORY_PIN};
         mod_s <= {mod_s[0], MODE_PIN};
         clr_s <= {clr_s[0], CLEAR_PIN};
         bck_s <= {bck_s[1:0], BIT_CLOCK_IN};
      end
   end

   // mode decode; the test combination is kept quiet like standby
   rdsrp_mode_t md;
   wire clr = clr_s[1];
   wire bck_fall = bck_s[2] & ~bck_s[1];
   assign md = mode_of(fac_s[1], mod_s[1]);
   wire is_master = (md == MD_MASTER);
   wire is_slave = (md == MD_SLAVE);
   wire quiet = (md == MD_STANDBY) | (md == MD_TEST);

   // ******************************************
   // bit buffer
   // ******************************************
   logic mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [AW:0] count;
   logic started, reliable, overrun, ready_q;
   wire empty = (count == '0);
   wire full = (count == (AW+1)'(DEPTH));
   // an empty queue shows the idle level, never a cell that was not written since reset
   wire head = empty ? 1'b1 : mem[rd_ptr];
   // storing waits for first detection, then runs regardless of it
   wire push = DEMOD_VALID & started & ~full & ~quiet & ~clr;
   wire pop_m, pop_s;
   wire pop = (pop_m | pop_s) & ~empty;
   wire flush = clr & is_slave;

   // storage itself has no reset, only the pointers
   always_ff @(posedge CLOCK) begin
      if (push) begin
         mem[wr_ptr] <= DEMOD_BIT;
      end
   end

   // one queue serves both readouts, so a mode switch in the master MST_LOW phase neither skips nor repeats
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (flush) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW)'(push);
         rd_ptr <= rd_ptr + (AW)'(pop);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // detection state; clear pin is a level, detection may not beat it
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         started <= 1'b0;
         reliable <= 1'b0;
         overrun <= 1'b0;
      end else if (clr) begin
         started <= 1'b0;
         reliable <= 1'b0;
         overrun <= 1'b0;
      end else begin
         started <= started | DETECT;
         reliable <= DEMOD_RELIABLE;
         overrun <= overrun | (DEMOD_VALID & started & full);
      end
   end

   // ready follows fill, one cycle behind
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ready_q <= 1'b0;
      end else begin
         ready_q <= is_slave & started & ~empty & ~flush;
      end
   end

   // ******************************************
   // master readout
   // ******************************************
   logic [31:0] ctrl;
   logic [15:0] div_cnt;
   logic tick, bclk, data_q;
   rdsrp_mst_t mst;
   wire [15:0] half = ctrl[CTRL_HALF_LSB +: 16];
   assign pop_m = is_master & started & (mst == MST_IDLE) & tick;
   assign pop_s = is_slave & bck_fall;

   // tick divider, three ticks per bit, a tick every half plus one cycles, so every cycle at zero
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         div_cnt <= '0;
         tick <= 1'b0;
      end else begin
         tick <= (div_cnt == '0);
         div_cnt <= (div_cnt == '0) ? half : div_cnt - 16'h1;
      end
   end

   // clock falls one tick after data changes, host samples on the fall
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         mst <= MST_IDLE;
         bclk <= 1'b1;
      end else if (!is_master || !started) begin
         mst <= MST_IDLE;
         bclk <= 1'b1;
      end else begin
         case (mst)
            MST_IDLE: begin
               if (pop) begin
                  mst <= MST_HIGH;
               end
            end
            MST_HIGH: begin
               if (tick) begin
                  bclk <= 1'b0;
                  mst <= MST_LOW;
               end
            end
            MST_LOW: begin
               if (tick) begin
                  bclk <= 1'b1;
                  mst <= MST_IDLE;
               end
            end
            default: mst <= MST_IDLE;
         endcase
      end
   end

   // data pin: held high before detection in master, head bit in slave
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         data_q <= 1'b1;
      end else if (is_master) begin
         if (!started) begin
            data_q <= 1'b1;
         end else if (pop) begin
            data_q <= head;
         end
      end else begin
         data_q <= head;
      end
   end

   // pins; the flag pin never drives high
   assign BIT_CLOCK_OUT = bclk;
   assign BIT_CLOCK_OE = is_master;
   assign SERIAL_DATA = data_q;
   assign FLAG_OUT = 1'b0;
   assign FLAG_OE = (is_master & ~reliable) | (is_slave & ~ready_q);
   assign STANDBY = quiet;

   // ******************************************
   // register bus
   // ******************************************
   logic aw_held, w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   wire aw_take = AWVALID & AWREADY;
   wire w_take = WVALID & WREADY;
   wire do_write = aw_held & w_held & ~BVALID;
   wire [31:0] status = (32'(count) << STAT_FILL_LSB)
      | (32'(ready_q) << STAT_READY_BIT) | (32'(started) << STAT_STARTED_BIT)
      | (32'(reliable) << STAT_RELIABLE_BIT) | (32'(overrun) << STAT_OVERRUN_BIT)
      | (32'(is_slave) << STAT_SLAVE_BIT) | (32'(quiet) << STAT_STANDBY_BIT);
   assign AWREADY = ~aw_held & ~BVALID;
   assign WREADY = ~w_held & ~BVALID;
   assign ARREADY = ~RVALID;

   // address and data taken in either order, answered when both are held
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         BVALID <= 1'b0;
         BRESP <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR;
         end
         if (w_take) begin
            w_held <= 1'b1;
            w_data <= WDATA;
            w_strb <= WSTRB;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= (aw_addr == CTRL_OFS || aw_addr == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // control word, byte lanes honoured; status writes are ignored
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ctrl <= CTRL_RESET;
      end else if (do_write && aw_addr == CTRL_OFS) begin
         for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
               ctrl[8*i +: 8] <= w_data[8*i +: 8];
            end
         end
      end
   end

   // reads answer one cycle after the address is taken
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RDATA <= (ARADDR == CTRL_OFS) ? ctrl : (ARADDR == STATUS_OFS) ? status : 32'h0;
         RRESP <= (ARADDR == CTRL_OFS || ARADDR == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // ******************************************
   // checks
   // ******************************************
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);

   master_pins_a: assert property (is_master |-> BIT_CLOCK_OE && (FLAG_OE == !reliable))
      else $error("master pin roles wrong");
   slave_pins_a: assert property (is_slave |-> !BIT_CLOCK_OE && (FLAG_OE == !ready_q))
      else $error("slave pin roles wrong");
   standby_quiet_a: assert property (quiet |-> STANDBY && !BIT_CLOCK_OE && !FLAG_OE)
      else $error("standby pins not released");
   clear_state_a: assert property (clr |=> !started && !reliable)
      else $error("clear left detection set");
   slave_flush_a: assert property (clr && is_slave |=> empty ##1 !ready_q)
      else $error("slave clear left buffer");
   master_flag_a: assert property (is_master && $past(is_master) && !$past(clr)
      |-> FLAG_OE == !$past(DEMOD_RELIABLE))
      else $error("flag not tracking reliability");
   flag_drain_a: assert property (!(FLAG_OE && FLAG_OUT))
      else $error("flag driven high");
   hold_high_a: assert property (is_master && !started && $past(is_master)
      |=> BIT_CLOCK_OUT && SERIAL_DATA)
      else $error("master pins not high before detection");
   slave_data_a: assert property (is_slave && $past(is_slave) |-> data_q == $past(head))
      else $error("slave data late");
   ready_drop_a: assert property (is_slave && count == 1 && pop && !push
      |-> ##[1:RC_MAX] !ready_q)
      else $error("ready not dropped when empty");
   ready_rise_a: assert property (is_slave && started && empty && push && !clr
      |-> ##[1:DV_MAX] ready_q)
      else $error("ready not raised on store");
   store_gate_a: assert property (!started |-> !push)
      else $error("stored before detection");
   keep_store_a: assert property (started && DEMOD_VALID && !full && !quiet && !clr |-> push)
      else $error("storing stopped after detection");
   fifo_order_a: assert property (pop && !flush |=> rd_ptr == $past(rd_ptr) + (AW)'(1))
      else $error("readout order broken");

   master_bit_c: cover property (is_master && bclk ##1 !bclk);
   slave_pop_c: cover property (is_slave && pop_s && !empty);
   ready_up_c: cover property (!ready_q ##1 ready_q);
   switch_c: cover property (is_master ##[1:8] is_slave);
endmodule

// [testbench/rdsrp_host.sv]
`timescale 1ns/1ps
// ******************************************
// host controller reading the slave link
// ******************************************
module rdsrp_host
   import rdsrp_pkg::*;
(
   input wire logic clk,
   input wire logic run,
   input wire logic ready,
   input wire logic data,
   output logic bit_clk,
   output logic [7:0] got,
   output logic [7:0] cnt
);
   // one bit per pass; the clock rests low whenever ready is low
   initial begin
      bit_clk = 1'b0;
      got = 8'h00;
      cnt = 8'h00;
      forever begin
         @(posedge clk);
         if (run && ready) begin
            // data has had a full delay since the last fall, so it is settled
            repeat (DATA_VALID_CYCLES) @(posedge clk);
            got <= {got[6:0], data};
            bit_clk <= 1'b1;
            repeat (DATA_VALID_CYCLES) @(posedge clk);
            bit_clk <= 1'b0;
            cnt <= cnt + 8'h01;
            // ready is only trusted after the check delay from the fall
            repeat (READY_CHECK_CYCLES) @(posedge clk);
         end
      end
   end
endmodule

// [testbench/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import rdsrp_pkg::*;
   logic CLOCK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic [3:0] AWADDR, ARADDR, WSTRB;
   logic [31:0] WDATA, RDATA, rd;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [1:0] BRESP, RRESP, rr;
   logic FACTORY_PIN, MODE_PIN, CLEAR_PIN, DEMOD_BIT, DEMOD_VALID, DEMOD_RELIABLE, DETECT;
   logic BIT_CLOCK_OUT, BIT_CLOCK_OE, SERIAL_DATA, FLAG_OUT, FLAG_OE, STANDBY;
   logic host_clk, host_run;
   logic bprev = 1'b0;
   logic [7:0] host_got, host_cnt;
   logic [7:0] mword = 8'h00;
   logic [7:0] mcnt = 8'h00;
   int error_cnt = 0;
   int cmp_count = 0;
   int cycles = 0;
   // shared pins: bit clock from whoever drives it, flag pin pulled up
   wire bit_pin = BIT_CLOCK_OE ? BIT_CLOCK_OUT : host_clk;
   wire ready_pin = !(FLAG_OE && !FLAG_OUT);

   rdsrp_top DUT (.CLOCK, .RESET_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
      .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
      .RVALID, .RREADY, .FACTORY_PIN, .MODE_PIN, .CLEAR_PIN, .DEMOD_BIT, .DEMOD_VALID,
      .DEMOD_RELIABLE, .DETECT, .BIT_CLOCK_IN(bit_pin), .BIT_CLOCK_OUT, .BIT_CLOCK_OE,
      .SERIAL_DATA, .FLAG_OUT, .FLAG_OE, .STANDBY);
   rdsrp_host host (.clk(CLOCK), .run(host_run), .ready(ready_pin), .data(SERIAL_DATA),
      .bit_clk(host_clk), .got(host_got), .cnt(host_cnt));

   // ******************************************
   // clock, watchdog and master-link monitor
   // ******************************************
   initial begin
      CLOCK = 1'b0;
      forever #12.5 CLOCK = ~CLOCK;
   end
   // watchdog: a hang counts as a mismatch and ends the run
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         $display("unexpected at %0t: timeout", $time);
         stop_test();
      end
   end
   // capture on the fall of the driven clock, where data is stable
   always @(posedge CLOCK) begin
      bprev <= BIT_CLOCK_OUT;
      if (BIT_CLOCK_OE && bprev && !BIT_CLOCK_OUT) begin
         mword <= {mword[6:0], SERIAL_DATA};
         mcnt <= mcnt + 8'h01;
      end
   end

   // ******************************************
   // shared tasks
   // ******************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   // both halves offered together, each dropped once taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
      end while (!BVALID);
      BREADY <= 1'b0;
      chk(BRESP, r, "write response");
   endtask
   task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (ARREADY) ARVALID <= 1'b0;
      end while (!RVALID);
      RREADY <= 1'b0;
      d = RDATA;
      r = RRESP;
   endtask
   // one demodulated bit every four cycles, msb first
   task automatic feed(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         DEMOD_BIT <= b[i];
         DEMOD_VALID <= 1'b1;
         @(posedge CLOCK);
         DEMOD_VALID <= 1'b0;
         repeat (3) @(posedge CLOCK);
      end
   endtask
   task automatic pulse_detect();
      DETECT <= 1'b1;
      @(posedge CLOCK);
      DETECT <= 1'b0;
   endtask
   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ******************************************
   // main sequence
   // ******************************************
   initial begin
      {AWADDR, ARADDR, WDATA, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      {FACTORY_PIN, MODE_PIN, CLEAR_PIN, DEMOD_BIT, DEMOD_VALID, DEMOD_RELIABLE} = '0;
      {DETECT, host_run} = '0;
      WSTRB = 4'hf;
      RESET_N = 1'b0;
      repeat (5) @(posedge CLOCK);
      RESET_N <= 1'b1;
      @(posedge CLOCK);
      chk({BIT_CLOCK_OUT, SERIAL_DATA}, 2'h3, "idle lines after reset");
      // register map: reset value, write back, unmapped places
      axr(CTRL_OFS, rd, rr);
      chk(rd, CTRL_RESET, "ctrl reset");
      axw(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
      axr(CTRL_OFS, rd, rr);
      chk(rd, 32'h0000_0003, "ctrl readback");
      axw(4'h8, 32'h0000_00ff, RESP_SLVERR);
      axr(4'hc, rd, rr);
      chk({rr, rd}, {RESP_SLVERR, 32'h0}, "unmapped read");
      // master: nothing moves or is kept before the first detection
      feed(8'hff);
      repeat (40) @(posedge CLOCK);
      chk({mcnt, BIT_CLOCK_OUT, SERIAL_DATA}, 10'h003, "held before detect");
      pulse_detect();
      DEMOD_RELIABLE <= 1'b1;
      feed(8'ha5);
      while (mcnt != 8'h08) @(posedge CLOCK);
      chk(mword, 8'ha5, "master bit order");
      chk(FLAG_OE, 1'b0, "flag released when reliable");
      DEMOD_RELIABLE <= 1'b0;
      feed(8'h0f);
      while (mcnt != 8'h10) @(posedge CLOCK);
      chk(mword, 8'h0f, "stored without detection");
      chk({FLAG_OE, FLAG_OUT}, 2'h2, "flag pulled low when unreliable");
      // master to slave mid-stream; slow clock so the switch lands in a low phase
      axw(CTRL_OFS, 32'h0000_000f, RESP_OKAY);
      feed(8'hc3);
      while (mcnt != 8'h13) @(posedge CLOCK);
      MODE_PIN <= 1'b1;
      host_run <= 1'b1;
      while (host_cnt != 8'h05) @(posedge CLOCK);
      repeat (READY_CHECK_CYCLES) @(posedge CLOCK);
      chk({mword[2:0], host_got[4:0]}, 8'hc3, "switch to slave keeps stream");
      chk(FLAG_OE, 1'b1, "ready low after drain");
      // back to master once ready has dropped; the link resumes with new data
      host_run <= 1'b0;
      MODE_PIN <= 1'b0;
      repeat (4) @(posedge CLOCK);
      feed(8'h96);
      while (mcnt != 8'h1b) @(posedge CLOCK);
      chk(mword, 8'h96, "master resumes after switch back");
      // slave: retune clear, refuse undetected data, then read through the handshake
      MODE_PIN <= 1'b1;
      CLEAR_PIN <= 1'b1;
      repeat (4) @(posedge CLOCK);
      CLEAR_PIN <= 1'b0;
      repeat (6) @(posedge CLOCK);
      chk({BIT_CLOCK_OE, FLAG_OE}, 2'h1, "slave after clear");
      axr(STATUS_OFS, rd, rr);
      chk(rd[STAT_SLAVE_BIT], 1'b1, "status slave bit");
      feed(8'hff);
      repeat (10) @(posedge CLOCK);
      chk(FLAG_OE, 1'b1, "no store before detect");
      pulse_detect();
      feed(8'h3c);
      repeat (4) @(posedge CLOCK);
      chk(FLAG_OE, 1'b0, "ready after store");
      host_run <= 1'b1;
      while (host_cnt != 8'h0d) @(posedge CLOCK);
      repeat (READY_CHECK_CYCLES) @(posedge CLOCK);
      chk(host_got, 8'h3c, "slave bit order");
      chk(FLAG_OE, 1'b1, "ready drops when empty");
      host_run <= 1'b0;
      // standby; mode drops with factory so the test pair is never applied
      MODE_PIN <= 1'b0;
      FACTORY_PIN <= 1'b1;
      repeat (4) @(posedge CLOCK);
      chk(STANDBY, 1'b1, "standby entered");
      FACTORY_PIN <= 1'b0;
      repeat (4) @(posedge CLOCK);
      chk({STANDBY, BIT_CLOCK_OE}, 2'h1, "back to master");
      stop_test();
   end
endmodule
